// ---- hw/ccm_top.sv ----
// coefficient checksum monitor: three xor checksum channels
// assumes: byte register port from the host interface, a shared
// coefficient ram port with one-cycle read latency, and a frame tick
// Function
// - three independent checksum channels
// - biquad sum xors ram words 0x00-0x27
// - biquad start exposes computed sum
// - biquad compare each frame into result bit
// - biquad auto-reset on mismatch, default off
// - crossover xor over 0x28-0x31, own expected
// - crossover start exposes computed sum
// - crossover compare each frame, 0 match
// - crossover auto-reset on mismatch, default off
// - splitter start writes sum into ram 0x73
// - splitter result bit 0 ok, 1 error
`timescale 1ns/100ps
module ccm_top
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  ccm_pkg::ccm_addr_t    reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr_en,
  input  wire logic             reg_rd_en,
  output logic [7:0]            reg_rdata,
  input  wire logic             frame_tick,
  output ccm_pkg::ccm_addr_t    ram_addr,
  output logic                  ram_rd_en,
  input  ccm_pkg::ccm_word_t    ram_rdata,
  output logic                  ram_wr_en,
  output ccm_pkg::ccm_word_t    ram_wdata,
  output logic                  dev_reset_req
);
  import ccm_pkg::*;
  `include "ccm_map.svh"

  // ***************************
  // storage
  // ***************************
  logic [7:0]  ctl_ff, spctl_ff;
  logic        bq_res_ff, xo_res_ff, sp_res_ff;
  ccm_word_t   bq_exp_ff, xo_exp_ff;
  ccm_word_t   bq_comp_ff, xo_comp_ff, sp_sum_ff;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        rst_req_ff;
  ccm_state_t  st_ff;
  ccm_job_t    job_ff, pick;
  logic [2:0]  pend_ff, go_q_ff, go_lvl, nxt_pend;
  logic        launch;
  ccm_addr_t   w_first, w_last, w_addr;
  logic        w_rd, w_done;
  ccm_word_t   w_sum;
  logic        bq_done, xo_done, bq_mis, xo_mis;

  assign go_lvl    = {spctl_ff[`CCM_B_SP_GO], ctl_ff[`CCM_B_XO_GO],
                      ctl_ff[`CCM_B_BQ_GO]};
  assign reg_rdata = rdata_ff;
  assign ram_wdata = sp_sum_ff;
  assign dev_reset_req = rst_req_ff;
  assign bq_done = (st_ff == CCM_ST_SCAN) && w_done && (job_ff == CCM_J_BQ);
  assign xo_done = (st_ff == CCM_ST_SCAN) && w_done && (job_ff == CCM_J_XO);
  assign bq_mis  = (w_sum != bq_exp_ff);
  assign xo_mis  = (w_sum != xo_exp_ff);

  // ***************************
  // host register writes
  // ***************************
  // result bits live apart, so host writes never clobber them
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_ff    <= `CCM_RST_CTL;
      spctl_ff  <= `CCM_RST_SPCTL;
      bq_exp_ff <= `CCM_RST_SUM;
      xo_exp_ff <= `CCM_RST_SUM;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        `CCM_A_CTL:   ctl_ff <= reg_wdata & ~`CCM_CTL_RO;
        `CCM_A_SPCTL: spctl_ff <= reg_wdata & ~`CCM_SPCTL_RO;
        `CCM_A_BQE0:  bq_exp_ff[23:16] <= reg_wdata;
        `CCM_A_BQE1:  bq_exp_ff[15:8]  <= reg_wdata;
        `CCM_A_BQE2:  bq_exp_ff[7:0]   <= reg_wdata;
        `CCM_A_XOE0:  xo_exp_ff[23:16] <= reg_wdata;
        `CCM_A_XOE1:  xo_exp_ff[15:8]  <= reg_wdata;
        `CCM_A_XOE2:  xo_exp_ff[7:0]   <= reg_wdata;
        default:      ctl_ff <= ctl_ff;
      endcase
    end
  end

  // ***************************
  // host register reads
  // ***************************
  always_comb
  begin
    nxt_rdata = ctl_ff;
    nxt_rdata[`CCM_B_BQ_RES] = bq_res_ff;
    nxt_rdata[`CCM_B_XO_RES] = xo_res_ff;
    case (reg_addr)
      `CCM_A_CTL:   nxt_rdata = nxt_rdata;
      `CCM_A_SPCTL: nxt_rdata = spctl_ff | {5'h00, sp_res_ff, 2'h0};
      `CCM_A_BQC0:  nxt_rdata = bq_comp_ff[23:16];
      `CCM_A_BQC1:  nxt_rdata = bq_comp_ff[15:8];
      `CCM_A_BQC2:  nxt_rdata = bq_comp_ff[7:0];
      `CCM_A_XOC0:  nxt_rdata = xo_comp_ff[23:16];
      `CCM_A_XOC1:  nxt_rdata = xo_comp_ff[15:8];
      `CCM_A_XOC2:  nxt_rdata = xo_comp_ff[7:0];
      `CCM_A_BQE0:  nxt_rdata = bq_exp_ff[23:16];
      `CCM_A_BQE1:  nxt_rdata = bq_exp_ff[15:8];
      `CCM_A_BQE2:  nxt_rdata = bq_exp_ff[7:0];
      `CCM_A_XOE0:  nxt_rdata = xo_exp_ff[23:16];
      `CCM_A_XOE1:  nxt_rdata = xo_exp_ff[15:8];
      `CCM_A_XOE2:  nxt_rdata = xo_exp_ff[7:0];
      default:      nxt_rdata = `CCM_RD_NONE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdata_ff <= `CCM_RD_NONE;
    else if (reg_rd_en)
      rdata_ff <= nxt_rdata;
  end

  // ***************************
  // job requests, one per channel
  // ***************************
  // a start edge or a frame with start held asks for a rescan;
  // a new request in the launch cycle wins over the clear
  always_comb
  begin
    nxt_pend = (go_lvl & ~go_q_ff) | ({3{frame_tick}} & go_lvl);
    nxt_pend = nxt_pend | (pend_ff & ~({2'b00, launch} << pick));
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_ff <= 3'h0;
      go_q_ff <= 3'h0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      go_q_ff <= go_lvl;
    end
  end

  // fixed priority keeps the longest range from starving
  always_comb
  begin
    pick    = pend_ff[0] ? CCM_J_BQ : (pend_ff[1] ? CCM_J_XO : CCM_J_SP);
    launch  = (st_ff == CCM_ST_IDLE) && (pend_ff != 3'h0);
    case (pick)
      CCM_J_BQ:
      begin
        w_first = `CCM_R_BQ_FIRST;
        w_last  = `CCM_R_BQ_LAST;
      end
      CCM_J_XO:
      begin
        w_first = `CCM_R_XO_FIRST;
        w_last  = `CCM_R_XO_LAST;
      end
      default:
      begin
        w_first = `CCM_R_SP_FIRST;
        w_last  = `CCM_R_SP_LAST;
      end
    endcase
  end

  ccm_xor_walker u_walk
  (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .go         (launch),
    .first_addr (w_first),
    .last_addr  (w_last),
    .ram_rdata  (ram_rdata),
    .rd_en      (w_rd),
    .addr       (w_addr),
    .done       (w_done),
    .sum        (w_sum)
  );

  // ***************************
  // sequencer
  // ***************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff  <= CCM_ST_IDLE;
      job_ff <= CCM_J_BQ;
    end
    else
    begin
      case (st_ff)
        CCM_ST_IDLE:
          if (launch)
          begin
            st_ff  <= CCM_ST_SCAN;
            job_ff <= pick;
          end
        CCM_ST_SCAN:
          if (w_done)
            st_ff <= (job_ff == CCM_J_SP) ? CCM_ST_RDEXP : CCM_ST_IDLE;
        CCM_ST_RDEXP: st_ff <= CCM_ST_WRSUM;
        CCM_ST_WRSUM: st_ff <= CCM_ST_IDLE;
        default:      st_ff <= CCM_ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    ram_rd_en = w_rd || (st_ff == CCM_ST_RDEXP);
    ram_wr_en = (st_ff == CCM_ST_WRSUM);
    case (st_ff)
      CCM_ST_RDEXP: ram_addr = `CCM_R_SP_EXP;
      CCM_ST_WRSUM: ram_addr = `CCM_R_SP_SUM;
      default:      ram_addr = w_addr;
    endcase
  end

  // ***************************
  // sums, compares, results
  // ***************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bq_comp_ff <= `CCM_RST_SUM;
      xo_comp_ff <= `CCM_RST_SUM;
      sp_sum_ff  <= `CCM_RST_SUM;
    end
    else if (st_ff == CCM_ST_SCAN && w_done)
      case (job_ff)
        CCM_J_BQ: bq_comp_ff <= w_sum;
        CCM_J_XO: xo_comp_ff <= w_sum;
        default:  sp_sum_ff  <= w_sum;
      endcase
  end

  // a stale result stays put while its compare is off
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bq_res_ff <= 1'b0;
      xo_res_ff <= 1'b0;
      sp_res_ff <= 1'b0;
    end
    else
    begin
      if (bq_done && ctl_ff[`CCM_B_BQ_CMP])
        bq_res_ff <= bq_mis;
      if (xo_done && ctl_ff[`CCM_B_XO_CMP])
        xo_res_ff <= xo_mis;
      if (st_ff == CCM_ST_WRSUM)
        sp_res_ff <= (ram_rdata != sp_sum_ff);
    end
  end

  // one pulse per failing compare with auto-reset on; the reset itself is the chip's
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rst_req_ff <= 1'b0;
    else
      rst_req_ff <= (bq_done && ctl_ff[`CCM_B_BQ_CMP] && bq_mis
                     && ctl_ff[`CCM_B_BQ_AUTO])
                 || (xo_done && ctl_ff[`CCM_B_XO_CMP] && xo_mis
                     && ctl_ff[`CCM_B_XO_AUTO]);
  end

  // ***************************
  // checks
  // ***************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_bq_range;
    w_rd && job_ff == CCM_J_BQ |-> ram_addr <= `CCM_R_BQ_LAST;
  endproperty
  a_bq_range: assert property (p_bq_range) else $error("bq addr out");
  property p_bq_comp;
    bq_done |=> bq_comp_ff == $past(w_sum);
  endproperty
  a_bq_comp: assert property (p_bq_comp) else $error("bq sum lost");
  property p_bq_res;
    bq_done && ctl_ff[`CCM_B_BQ_CMP]
      |=> bq_res_ff == ($past(w_sum) != bq_exp_ff);
  endproperty
  a_bq_res: assert property (p_bq_res) else $error("bq result wrong");
  property p_xo_res;
    xo_done && ctl_ff[`CCM_B_XO_CMP]
      |=> xo_res_ff == ($past(w_sum) != xo_exp_ff);
  endproperty
  a_xo_res: assert property (p_xo_res) else $error("xo result wrong");
  property p_hold;
    !ctl_ff[`CCM_B_BQ_CMP] |=> $stable(bq_res_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("bq result moved");
  property p_bq_rst;
    bq_done && ctl_ff[`CCM_B_BQ_CMP] && ctl_ff[`CCM_B_BQ_AUTO] && bq_mis
      |=> dev_reset_req;
  endproperty
  a_bq_rst: assert property (p_bq_rst) else $error("no bq reset");
  property p_rst_cause;
    dev_reset_req |-> $past(ctl_ff[`CCM_B_BQ_AUTO] || ctl_ff[`CCM_B_XO_AUTO]);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("stray reset");
  property p_sp_wr;
    st_ff == CCM_ST_WRSUM |-> ram_wr_en && ram_addr == `CCM_R_SP_SUM;
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("sum not written");
  property p_sp_res;
    st_ff == CCM_ST_WRSUM |=> sp_res_ff == ($past(ram_rdata) != sp_sum_ff);
  endproperty
  a_sp_res: assert property (p_sp_res) else $error("sp result wrong");
  c_bq_mis: cover property (bq_done && ctl_ff[`CCM_B_BQ_CMP] && bq_mis);
  c_xo_rst: cover property (dev_reset_req && ctl_ff[`CCM_B_XO_AUTO]);
  c_sp_wr:  cover property (st_ff == CCM_ST_WRSUM);
endmodule : ccm_top

// ---- hw/ccm_map.svh ----
// address map, bit positions, ranges and reset values of the monitor
// assumes: included by bare name wherever the map is needed
`ifndef CCM_MAP_SVH
`define CCM_MAP_SVH

// ***************************
// register offsets
// ***************************
`define CCM_A_SPCTL   8'h5a
`define CCM_A_BQC0    8'h60
`define CCM_A_BQC1    8'h61
`define CCM_A_BQC2    8'h62
`define CCM_A_XOC0    8'h63
`define CCM_A_XOC1    8'h64
`define CCM_A_XOC2    8'h65
`define CCM_A_BQE0    8'h66
`define CCM_A_BQE1    8'h67
`define CCM_A_BQE2    8'h68
`define CCM_A_XOE0    8'h69
`define CCM_A_XOE1    8'h6a
`define CCM_A_XOE2    8'h6b
`define CCM_A_CTL     8'h6c

// ***************************
// control bit positions
// ***************************
`define CCM_B_BQ_GO   0
`define CCM_B_BQ_CMP  1
`define CCM_B_BQ_RES  2
`define CCM_B_BQ_AUTO 3
`define CCM_B_XO_GO   4
`define CCM_B_XO_CMP  5
`define CCM_B_XO_RES  6
`define CCM_B_XO_AUTO 7
`define CCM_B_SP_GO   0
`define CCM_B_SP_RES  2

// ***************************
// coefficient ram ranges
// ***************************
`define CCM_R_BQ_FIRST 8'h00
`define CCM_R_BQ_LAST  8'h27
`define CCM_R_XO_FIRST 8'h28
`define CCM_R_XO_LAST  8'h31
`define CCM_R_SP_FIRST 8'h40
`define CCM_R_SP_LAST  8'h53
`define CCM_R_SP_EXP   8'h72
`define CCM_R_SP_SUM   8'h73

// ***************************
// reset values and masks
// ***************************
`define CCM_RST_CTL    8'h00
`define CCM_RST_SPCTL  8'h30
`define CCM_RST_SUM    24'h000000
`define CCM_CTL_RO     8'h44
`define CCM_SPCTL_RO   8'h04
`define CCM_RD_NONE    8'h00

`endif

// ---- hw/ccm_pkg.sv ----
// types shared by the coefficient checksum monitor
// assumes: nothing beyond the map header
package ccm_pkg;
  typedef logic [7:0]  ccm_addr_t;
  typedef logic [23:0] ccm_word_t;
  typedef enum logic [1:0]
  {
    CCM_ST_IDLE  = 2'b00,
    CCM_ST_SCAN  = 2'b01,
    CCM_ST_RDEXP = 2'b11,
    CCM_ST_WRSUM = 2'b10
  } ccm_state_t;
  typedef enum logic [1:0]
  {
    CCM_J_BQ = 2'b00,
    CCM_J_XO = 2'b01,
    CCM_J_SP = 2'b10
  } ccm_job_t;
endpackage : ccm_pkg

// ---- hw/ccm_xor_walker.sv ----
// walks a coefficient ram range and folds the words by xor
// assumes: ram read data is valid one cycle after the read strobe
`timescale 1ns/100ps
module ccm_xor_walker
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             go,
  input  ccm_pkg::ccm_addr_t    first_addr,
  input  ccm_pkg::ccm_addr_t    last_addr,
  input  ccm_pkg::ccm_word_t    ram_rdata,
  output logic                  rd_en,
  output ccm_pkg::ccm_addr_t    addr,
  output logic                  done,
  output ccm_pkg::ccm_word_t    sum
);
  import ccm_pkg::*;
  `include "ccm_map.svh"

  logic       busy_ff;
  ccm_addr_t  addr_ff;
  ccm_addr_t  last_ff;
  logic       pend_ff;
  logic       pend_last_ff;
  logic       done_ff;
  ccm_word_t  acc_ff;

  assign rd_en = busy_ff;
  assign addr  = addr_ff;
  assign done  = done_ff;
  assign sum   = acc_ff;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_ff <= 1'b0;
      addr_ff <= `CCM_R_BQ_FIRST;
      last_ff <= `CCM_R_BQ_FIRST;
    end
    else if (go && !busy_ff)
    begin
      busy_ff <= 1'b1;
      addr_ff <= first_addr;
      last_ff <= last_addr;
    end
    else if (busy_ff)
    begin
      addr_ff <= addr_ff + 8'h01;
      busy_ff <= (addr_ff != last_ff);
    end
  end

  // read data lags the strobe, so fold one cycle late
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_ff      <= 1'b0;
      pend_last_ff <= 1'b0;
      done_ff      <= 1'b0;
      acc_ff       <= `CCM_RST_SUM;
    end
    else
    begin
      pend_ff      <= busy_ff;
      pend_last_ff <= busy_ff && (addr_ff == last_ff);
      done_ff      <= pend_last_ff;
      if (go && !busy_ff)
        acc_ff <= `CCM_RST_SUM;
      else if (pend_ff)
        acc_ff <= acc_ff ^ ram_rdata;
    end
  end

  // ***************************
  // checks
  // ***************************
  // longest range is 40 words, done follows two cycles after the last read
  property p_scan_end;
    @(posedge clk_sys) disable iff (!arst_n)
    go && !busy_ff |-> ##[2:48] done_ff;
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan hung");
endmodule : ccm_xor_walker

// ---- sim/ccm_coef_ram.sv ----
// coefficient ram model facing the monitor's ram port
// assumes: one-cycle read latency, bench preloads words by hierarchy
`timescale 1ns/100ps
module ccm_coef_ram
(
  input  wire logic          clk_sys,
  input  ccm_pkg::ccm_addr_t ram_addr,
  input  wire logic          ram_rd_en,
  output ccm_pkg::ccm_word_t ram_rdata,
  input  wire logic          ram_wr_en,
  input  ccm_pkg::ccm_word_t ram_wdata
);
  import ccm_pkg::*;
  // ***************************
  // storage
  // ***************************
  // holds coefficients and the splitter expected word
  ccm_word_t mem [0:255];
  // idle cycles flip the bus so stale data never looks valid
  always @(posedge clk_sys)
  begin
    if (ram_wr_en === 1'b1)
      mem[ram_addr] <= ram_wdata;
    if (ram_rd_en === 1'b1)
      ram_rdata <= mem[ram_addr];
    else
      ram_rdata <= ~ram_rdata;
  end
endmodule : ccm_coef_ram

// ---- sim/testbench.sv ----
// self-checking bench for the coefficient checksum monitor
// assumes: ram model answers reads one cycle late
`timescale 1ns/100ps
`include "ccm_map.svh"
module testbench;
  import ccm_pkg::*;
  // ***************************
  // signals
  // ***************************
  logic       clk_sys    = 1'b0;
  logic       arst_n     = 1'b0;
  ccm_addr_t  reg_addr   = 8'h00;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr_en  = 1'b0;
  logic       reg_rd_en  = 1'b0;
  logic       frame_tick = 1'b0;
  logic [7:0] reg_rdata;
  ccm_addr_t  ram_addr;
  logic       ram_rd_en;
  ccm_word_t  ram_rdata;
  logic       ram_wr_en;
  ccm_word_t  ram_wdata;
  logic       dev_reset_req;
  int         err_total  = 0;
  int         tests_run  = 0;
  int         rst_cnt    = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (dev_reset_req === 1'b1) rst_cnt++;
  ccm_top i_ccm_top (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr_en, .reg_rd_en, .reg_rdata, .frame_tick, .ram_addr,
    .ram_rd_en, .ram_rdata, .ram_wr_en, .ram_wdata, .dev_reset_req);
  ccm_coef_ram i_ccm_coef_ram (.clk_sys, .ram_addr, .ram_rd_en,
    .ram_rdata, .ram_wr_en, .ram_wdata);
  // ***************************
  // shared tasks
  // ***************************
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : check
  task automatic wr(input ccm_addr_t a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask : wr
  // masked read so a frozen bit of the other channel is left out
  task automatic rdc(input ccm_addr_t a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] d;
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 d = reg_rdata;
    check({16'h0000, d & m}, {16'h0000, e});
  endtask : rdc
  task automatic scan_wait();
    int n;
    n = 0;
    while (ram_rd_en !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    while (ram_rd_en === 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    repeat (8) @(posedge clk_sys);
    check(24'(n < 300), 24'h000001);
  endtask : scan_wait
  task automatic frame();
    @(posedge clk_sys);
    frame_tick <= 1'b1;
    @(posedge clk_sys);
    frame_tick <= 1'b0;
    scan_wait();
  endtask : frame
  task automatic fill(input ccm_addr_t lo, input ccm_addr_t hi,
                      output ccm_word_t s);
    s = 24'h000000;
    for (int i = int'(lo); i <= int'(hi); i++)
    begin
      i_ccm_coef_ram.mem[i] = 24'h5a3c00 ^ 24'(i * 32'h00010307);
      s ^= i_ccm_coef_ram.mem[i];
    end
  endtask : fill
  // ***************************
  // scenarios
  // ***************************
  task automatic reset_vals();
    rdc(`CCM_A_CTL, 8'hff, `CCM_RST_CTL);
    rdc(`CCM_A_SPCTL, 8'hff, `CCM_RST_SPCTL);
    wr(`CCM_A_BQC0, 8'hff);
    rdc(`CCM_A_BQC0, 8'hff, 8'h00);
    rdc(8'h70, 8'hff, 8'h00);
    wr(`CCM_A_CTL, 8'h44);
    rdc(`CCM_A_CTL, 8'hff, 8'h00);
    $display("reset values done");
  endtask : reset_vals
  // one channel of the shared control byte, g is its start bit
  task automatic chan(input int g, input ccm_addr_t lo, input ccm_addr_t hi,
                      input ccm_addr_t ca, input ccm_addr_t ea);
    ccm_word_t  s;
    logic [7:0] m;
    int         r0;
    m = 8'(8'h0f << g);
    fill(lo, hi, s);
    for (int k = 0; k < 3; k++)
      wr(ea + 8'(k), s[23-8*k -: 8]);
    rdc(ea, 8'hff, s[23:16]);
    wr(`CCM_A_CTL, 8'(1 << g));
    scan_wait();
    for (int k = 0; k < 3; k++)
      rdc(ca + 8'(k), 8'hff, s[23-8*k -: 8]);
    wr(`CCM_A_CTL, 8'(3 << g));
    frame();
    rdc(`CCM_A_CTL, m, 8'(3 << g));
    wr(ea + 8'h02, ~s[7:0]);
    wr(`CCM_A_CTL, 8'(11 << g));
    r0 = rst_cnt;
    frame();
    rdc(`CCM_A_CTL, m, 8'(15 << g));
    check(24'(rst_cnt - r0), 24'h000001);
    wr(`CCM_A_CTL, 8'(9 << g));
    wr(ea + 8'h02, s[7:0]);
    r0 = rst_cnt;
    frame();
    rdc(`CCM_A_CTL, m, 8'(13 << g));
    check(24'(rst_cnt - r0), 24'h000000);
    wr(`CCM_A_CTL, 8'h00);
    $display("channel at bit %0d done", g);
  endtask : chan
  task automatic splitter();
    ccm_word_t s;
    fill(`CCM_R_SP_FIRST, `CCM_R_SP_LAST, s);
    i_ccm_coef_ram.mem[`CCM_R_SP_EXP] = s;
    wr(`CCM_A_SPCTL, 8'h31);
    scan_wait();
    check(i_ccm_coef_ram.mem[`CCM_R_SP_SUM], s);
    rdc(`CCM_A_SPCTL, 8'hff, 8'h31);
    i_ccm_coef_ram.mem[`CCM_R_SP_EXP] = ~s;
    wr(`CCM_A_SPCTL, 8'h30);
    wr(`CCM_A_SPCTL, 8'h31);
    scan_wait();
    rdc(`CCM_A_SPCTL, 8'hff, 8'h35);
    wr(`CCM_A_SPCTL, 8'h30);
    $display("splitter done");
  endtask : splitter
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // ***************************
  // sequence and watchdog
  // ***************************
  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    reset_vals();
    chan(0, `CCM_R_BQ_FIRST, `CCM_R_BQ_LAST, `CCM_A_BQC0, `CCM_A_BQE0);
    chan(4, `CCM_R_XO_FIRST, `CCM_R_XO_LAST, `CCM_A_XOC0, `CCM_A_XOE0);
    splitter();
    rdc(`CCM_A_CTL, 8'hff, 8'h44);
    tally_and_finish();
  end
  // all scans together need a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
endmodule : testbench
